/* File: design/hbsc_regs.sv */
// Serial-reachable configuration, fault and identification registers of the bridge driver.
`timescale 1ns/1ns

// What this block does
// - Writing back the last-read value clears those bits, restoring register defaults.
// - In serial control the two direction bits set which output drives higher.
// - In parallel control both serial direction bits are ignored.
// - Source select 0 takes bridge control from the two parallel pins.
// - Source select 1 takes bridge control from the serial direction bits.
// - Topology bit picks full or half bridge; full bridge by default.
// - Two-bit field selects one of four current limit levels.
// - Three-bit field selects one of eight slew rate settings.
// - Test bit set runs an open-load test on the next standby entry.
// - The standby open-load test never runs in half-bridge operation.
// - Mask bit 0: overvoltage sets its flag and forces high-side recirculation.
// - Mask bit 1: overvoltage only sets its flag, outputs untouched.
// - Overvoltage recirculation is never applied in half-bridge operation.
module hbsc_regs #(
  parameter logic [3:0] REVISION = hbsc_pkg::REVISION_DEFAULT
) (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic mosi,
  output logic miso,
  output logic miso_oe,
  input wire logic parallel_pin_a,
  input wire logic parallel_pin_b,
  input wire logic standby_req,
  input wire hbsc_pkg::hbsc_fault_t fault_in,
  output logic bridge_output_a,
  output logic bridge_output_b,
  output logic half_bridge_mode,
  output logic output_enable,
  output logic [1:0] current_limit,
  output logic [2:0] slew_sel,
  output logic openload_test_start,
  output logic overvoltage_recirculate
);

  typedef struct packed {
    logic sclk_q;
    logic cs_q;
    logic standby_q;
    logic [15:0] shift_in;
    logic [15:0] shift_out;
    logic [4:0] bit_cnt;
    logic [1:0] answer_addr;
    logic [3:0][12:0] last_read;
    logic [12:0] status;
    logic [12:0] mask;
    hbsc_pkg::hbsc_cfg_t cfg;
    logic miso;
    logic miso_oe;
    logic drive_a;
    logic drive_b;
    logic openload_start;
    logic recirculate;
  } hbsc_state_t;

  hbsc_state_t st;
  hbsc_state_t next_st;
  hbsc_pkg::hbsc_pins_t pins_raw;
  hbsc_pkg::hbsc_pins_t pins;
  logic framing_set;
  logic [12:0] status_clear;
  logic [1:0] word_addr;
  logic [12:0] word_data;
  logic [12:0] answer_value;

  // Register read mux shared by the answer path.
  function automatic logic [12:0] reg_value(input logic [1:0] addr, input hbsc_state_t s);
    logic [12:0] value;
    value = '0;
    case (addr)
      hbsc_pkg::ADDR_ID: value = {hbsc_pkg::ID_PAD, REVISION};
      hbsc_pkg::ADDR_STATUS: value = s.status;
      hbsc_pkg::ADDR_MASK: value = s.mask;
      hbsc_pkg::ADDR_CONFIG: value = s.cfg;
      default: value = '0;
    endcase
    return value;
  endfunction : reg_value

  // Gather every asynchronous input for the synchroniser.
  assign pins_raw = '{sclk: sclk, cs_n: cs_n, mosi: mosi, parallel_pin_a: parallel_pin_a,
                      parallel_pin_b: parallel_pin_b, standby_req: standby_req,
                      faults: fault_in};

  hbsc_sync #(
    .WIDTH(hbsc_pkg::PINS_BITS),
    .RESET_VALUE(hbsc_pkg::PINS_RESET)
  ) u_sync (
    .clock(clock),
    .reset_n(reset_n),
    .async_in(pins_raw),
    .sync_out(pins)
  );

  // Decoded fields of the word received in the frame just closed.
  assign word_addr = st.shift_in[hbsc_pkg::ADDR_MSB:hbsc_pkg::ADDR_LSB];
  assign word_data = st.shift_in[hbsc_pkg::DATA_BITS-1:0];
  assign answer_value = reg_value(st.answer_addr, st);

  // Serial shifting, register writes, fault capture and bridge control.
  always_comb begin
    next_st = st;
    framing_set = 1'b0;
    status_clear = '0;
    next_st.sclk_q = pins.sclk;
    next_st.cs_q = pins.cs_n;
    next_st.standby_q = pins.standby_req;
    next_st.miso_oe = !pins.cs_n;

    if (!pins.cs_n && st.cs_q) begin
      // Frame start: load the answer selected by the previous frame.
      next_st.shift_out = {hbsc_pkg::ANSWER_PAD, answer_value};
      next_st.last_read[st.answer_addr] = answer_value;
      next_st.miso = 1'b0; // The zero pad bit leads every answer.
      next_st.bit_cnt = '0;
    end else if (!pins.cs_n) begin
      // Sample on the rising serial edge, shift out on the falling one.
      if (pins.sclk && !st.sclk_q) begin
        next_st.shift_in = {st.shift_in[14:0], pins.mosi};
        if (st.bit_cnt != hbsc_pkg::COUNT_MAX) begin
          next_st.bit_cnt = st.bit_cnt + 5'h01;
        end
      end
      if (!pins.sclk && st.sclk_q) begin
        next_st.shift_out = {st.shift_out[14:0], 1'b0};
        next_st.miso = st.shift_out[14];
      end
    end

    if (pins.cs_n && !st.cs_q) begin
      // Frame end: a word of the wrong length is flagged and discarded.
      if (st.bit_cnt != hbsc_pkg::WORD_COUNT) begin
        framing_set = 1'b1;
      end else begin
        next_st.answer_addr = word_addr;
        if (st.shift_in[hbsc_pkg::WRITE_POS]) begin
          case (word_addr)
            hbsc_pkg::ADDR_STATUS: begin
              status_clear = word_data & st.last_read[hbsc_pkg::ADDR_STATUS];
            end
            hbsc_pkg::ADDR_MASK: begin
              if (word_data == st.last_read[hbsc_pkg::ADDR_MASK]) begin
                next_st.mask = hbsc_pkg::MASK_RESET;
              end else begin
                next_st.mask = word_data;
              end
            end
            hbsc_pkg::ADDR_CONFIG: begin
              if (word_data == st.last_read[hbsc_pkg::ADDR_CONFIG]) begin
                next_st.cfg = hbsc_pkg::CONFIG_RESET;
              end else begin
                next_st.cfg = word_data;
              end
            end
            default: begin
            end
          endcase
        end
      end
    end

    // Sticky fault flags; a new event wins over a clear in the same cycle.
    next_st.status = (st.status & ~status_clear) | {1'b0, framing_set, pins.faults};

    // Bridge direction from the selected control source.
    if (st.cfg.spi_ctrl_sel) begin
      next_st.drive_a = st.cfg.spi_dir_bit_a;
      next_st.drive_b = st.cfg.spi_dir_bit_b;
    end else begin
      next_st.drive_a = pins.parallel_pin_a;
      next_st.drive_b = pins.parallel_pin_b;
    end

    // Open-load test request on standby entry, full bridge only.
    next_st.openload_start = pins.standby_req && !st.standby_q
                             && st.cfg.standby_openload_test_en
                             && !st.cfg.half_bridge_mode;

    // High-side recirculation while overvoltage persists, unless masked or half bridge.
    next_st.recirculate = pins.faults.overvoltage_flag
                          && !st.mask[hbsc_pkg::MASK_DISABLE_POS]
                          && !st.cfg.half_bridge_mode;
  end

  // State register with constant reset values.
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      st <= '{cs_q: 1'b1, last_read: '0, status: hbsc_pkg::STATUS_RESET,
              mask: hbsc_pkg::MASK_RESET, cfg: hbsc_pkg::CONFIG_RESET, default: '0};
    end else begin
      st <= next_st;
    end
  end

  // Every output comes straight from the state register.
  assign miso = st.miso;
  assign miso_oe = st.miso_oe;
  assign bridge_output_a = st.drive_a;
  assign bridge_output_b = st.drive_b;
  assign half_bridge_mode = st.cfg.half_bridge_mode;
  assign output_enable = st.cfg.output_enable;
  assign current_limit = st.cfg.current_limit;
  assign slew_sel = st.cfg.slew_sel;
  assign openload_test_start = st.openload_start;
  assign overvoltage_recirculate = st.recirculate;

endmodule : hbsc_regs

/* File: design/hbsc_pkg.sv */
// Shared constants and carrier types for the bridge configuration register bank.
package hbsc_pkg;

  // Serial word framing: write flag, register address, then the data field.
  localparam int WORD_BITS = 16;
  localparam int DATA_BITS = 13;
  localparam int WRITE_POS = 15;
  localparam int ADDR_MSB = 14;
  localparam int ADDR_LSB = 13;
  localparam logic [4:0] WORD_COUNT = 5'h10;
  localparam logic [4:0] COUNT_MAX = 5'h1F;
  localparam logic [2:0] ANSWER_PAD = 3'h0;

  // Register addresses.
  localparam logic [1:0] ADDR_ID = 2'h0;
  localparam logic [1:0] ADDR_STATUS = 2'h1;
  localparam logic [1:0] ADDR_MASK = 2'h2;
  localparam logic [1:0] ADDR_CONFIG = 2'h3;

  // Field positions inside the mask register.
  localparam int MASK_DISABLE_POS = 12;

  // Reset values; the configuration default sets direction bit A but leaves the parallel pins in control.
  localparam logic [12:0] STATUS_RESET = 13'h0000;
  localparam logic [12:0] MASK_RESET = 13'h0000;
  localparam logic [12:0] CONFIG_RESET = 13'h0001;
  localparam logic [8:0] ID_PAD = 9'h000;
  localparam logic [3:0] REVISION_DEFAULT = 4'h1; // Arbitrary value.

  // Configuration and control register, bit 12 down to bit 0.
  typedef struct packed {
    logic standby_openload_test_en;
    logic test_mode_sel;
    logic aux_ctrl;
    logic [1:0] current_limit;
    logic [2:0] slew_sel;
    logic output_enable;
    logic half_bridge_mode;
    logic spi_ctrl_sel;
    logic spi_dir_bit_b;
    logic spi_dir_bit_a;
  } hbsc_cfg_t;

  // Fault condition levels from the analog side, bit 10 down to bit 0.
  typedef struct packed {
    logic charge_pump_low_flag;
    logic undervoltage_flag;
    logic overvoltage_flag;
    logic short_supply_out_b;
    logic short_supply_out_a;
    logic short_ground_out_b;
    logic short_ground_out_a;
    logic open_load_flag;
    logic overcurrent_flag;
    logic thermal_warning_flag;
    logic overtemperature_flag;
  } hbsc_fault_t;

  // All asynchronous inputs, carried together through the synchroniser.
  typedef struct packed {
    logic sclk;
    logic cs_n;
    logic mosi;
    logic parallel_pin_a;
    logic parallel_pin_b;
    logic standby_req;
    hbsc_fault_t faults;
  } hbsc_pins_t;

  localparam int PINS_BITS = $bits(hbsc_pins_t);
  localparam hbsc_pins_t PINS_RESET = '{cs_n: 1'b1, default: '0};

endpackage : hbsc_pkg

/* File: design/hbsc_sync.sv */
// Two-stage synchroniser for a bundle of asynchronous inputs.
`timescale 1ns/1ns
module hbsc_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  typedef struct packed {
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
  } hbsc_sync_state_t;

  hbsc_sync_state_t st;
  hbsc_sync_state_t next_st;

  // The first stage feeds only the second stage.
  always_comb begin
    next_st.stage1 = async_in;
    next_st.stage2 = st.stage1;
  end

  // Both stages settle to the idle value under reset.
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      st <= '{stage1: RESET_VALUE, stage2: RESET_VALUE};
    end else begin
      st <= next_st;
    end
  end

  assign sync_out = st.stage2;

endmodule : hbsc_sync

/* File: bench/hbsc_regs_asserts.sv */
// Port-level checks of the bridge register bank.
`timescale 1ns/1ns
module hbsc_regs_asserts (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic cs_n,
  input wire logic parallel_pin_a,
  input wire logic standby_req,
  input wire hbsc_pkg::hbsc_fault_t fault_in,
  input wire logic miso_oe,
  input wire logic bridge_output_a,
  input wire logic half_bridge_mode,
  input wire logic output_enable,
  input wire logic [1:0] current_limit,
  input wire logic [2:0] slew_sel,
  input wire logic openload_test_start,
  input wire logic overvoltage_recirculate
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);
  // Protection and test outputs against their causes.
  AST_OV_HALF: assert property (half_bridge_mode && $past(half_bridge_mode) |-> !overvoltage_recirculate)
    else $error("Recirculation in half bridge.");
  AST_OV_CAUSE: assert property (overvoltage_recirculate |-> $past(fault_in.overvoltage_flag, 3))
    else $error("Recirculation without overvoltage.");
  AST_OL_HALF: assert property (openload_test_start |-> !$past(half_bridge_mode))
    else $error("Open-load test in half bridge.");
  AST_OL_PULSE: assert property (openload_test_start |=> !openload_test_start)
    else $error("Open-load start longer than one cycle.");
  AST_OL_CAUSE: assert property (openload_test_start |-> $past(standby_req, 3))
    else $error("Open-load start without standby.");
  // Settings move only after a frame closes.
  AST_CFG_FRAME: assert property ($changed(current_limit) || $changed(slew_sel) ||
    $changed(output_enable) |-> $past(cs_n, 3))
    else $error("Settings changed inside a frame.");
  AST_DIR_SRC: assert property ($changed(bridge_output_a) |-> $past(cs_n, 3) ||
    ($past(parallel_pin_a, 3) != $past(parallel_pin_a, 4)))
    else $error("Drive changed without a cause.");
  AST_OE_IDLE: assert property (cs_n [*5] |-> !miso_oe)
    else $error("Serial output driven while idle.");
endmodule : hbsc_regs_asserts
bind hbsc_regs hbsc_regs_asserts hbsc_regs_asserts_i (.clock(clock), .reset_n(reset_n),
  .cs_n(cs_n), .parallel_pin_a(parallel_pin_a), .standby_req(standby_req),
  .fault_in(fault_in), .miso_oe(miso_oe), .bridge_output_a(bridge_output_a),
  .half_bridge_mode(half_bridge_mode), .output_enable(output_enable),
  .current_limit(current_limit), .slew_sel(slew_sel),
  .openload_test_start(openload_test_start), .overvoltage_recirculate(overvoltage_recirculate));

/* File: bench/hbsc_host.sv */
// Serial host model that frames words to the register bank.
`timescale 1ns/1ns
module hbsc_host (
  input wire logic clock,
  output logic sclk,
  output logic cs_n,
  output logic mosi,
  input wire logic miso
);
  // Idle levels before the first frame.
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    mosi = 1'b0;
  end
  // Released data line keeps toggling so a stale bit is never mistaken for data.
  always @(posedge clock) begin
    if (cs_n) begin
      mosi <= ~mosi;
    end
  end
  // One frame, MSB first, the first n bits of the word; clock stands low between frames.
  // Every pin moves on a system clock edge; four edges make half a 400 ns serial period.
  task automatic xfer(input logic [15:0] w, input int n, output logic [15:0] r);
    r = 16'h0000;
    @(posedge clock);
    cs_n <= 1'b0;
    repeat (4) @(posedge clock);
    for (int i = 0; i < n; i++) begin
      mosi <= w[15 - i];
      repeat (4) @(posedge clock);
      r = {r[14:0], miso};
      sclk <= 1'b1;
      repeat (4) @(posedge clock);
      sclk <= 1'b0;
    end
    repeat (4) @(posedge clock);
    cs_n <= 1'b1;
    repeat (8) @(posedge clock);
  endtask : xfer
endmodule : hbsc_host

/* File: bench/testbench.sv */
// Self-checking bench for the bridge register bank.
`timescale 1ns/1ns
module testbench;
  logic clock, reset_n, sclk, cs_n, mosi, miso, parallel_pin_a, parallel_pin_b, standby_req;
  logic bridge_output_a, bridge_output_b, half_bridge_mode, output_enable, miso_oe;
  // The host sees a released data line as the inverse of its last bit.
  wire host_miso = miso_oe ? miso : !miso;
  logic openload_test_start, overvoltage_recirculate;
  logic [1:0] current_limit;
  logic [2:0] slew_sel;
  logic [15:0] r;
  hbsc_pkg::hbsc_fault_t fault_in;
  int err_total, checks, pulses;
  wire [15:0] outs = {5'h00, miso_oe, bridge_output_a, bridge_output_b, output_enable,
    half_bridge_mode,
    overvoltage_recirculate, current_limit, slew_sel};
  hbsc_regs hbsc_regs_i (.clock(clock), .reset_n(reset_n), .sclk(sclk), .cs_n(cs_n),
    .mosi(mosi), .miso(miso), .miso_oe(miso_oe), .parallel_pin_a(parallel_pin_a),
    .parallel_pin_b(parallel_pin_b), .standby_req(standby_req), .fault_in(fault_in),
    .bridge_output_a(bridge_output_a), .bridge_output_b(bridge_output_b),
    .half_bridge_mode(half_bridge_mode), .output_enable(output_enable),
    .current_limit(current_limit), .slew_sel(slew_sel),
    .openload_test_start(openload_test_start),
    .overvoltage_recirculate(overvoltage_recirculate));
  hbsc_host hbsc_host_i (.clock(clock), .sclk(sclk), .cs_n(cs_n), .mosi(mosi),
    .miso(host_miso));
  // Compares one value and counts the outcome.
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic end_sim();
    $display("checks %0d err_total %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : end_sim
  task automatic wr(input logic [1:0] a, input logic [12:0] d);
    hbsc_host_i.xfer({1'b1, a, d}, 16, r);
  endtask : wr
  // A read answers in the following frame.
  task automatic rd(input logic [1:0] a);
    hbsc_host_i.xfer({1'b0, a, 13'h0000}, 16, r);
    hbsc_host_i.xfer({1'b0, hbsc_pkg::ADDR_ID, 13'h0000}, 16, r);
  endtask : rd
  task automatic pins(input logic [10:0] f, input logic a, input logic b, input logic s);
    @(posedge clock);
    fault_in <= f;
    parallel_pin_a <= a;
    parallel_pin_b <= b;
    standby_req <= s;
    repeat (8) @(posedge clock);
  endtask : pins
  // Counts open-load start pulses.
  always @(posedge clock) if (openload_test_start === 1'b1) pulses++;
  initial begin
    clock = 0;
    forever #25 clock = ~clock;
  end
  // Main sequence.
  initial begin
    reset_n = 0;
    fault_in = '0;
    {parallel_pin_a, parallel_pin_b, standby_req} = 3'h0;
    {err_total, checks, pulses} = '0;
    repeat (3) @(posedge clock);
    reset_n <= 1;
    repeat (4) @(posedge clock);
    chk(outs, 16'h0000);
    wr(hbsc_pkg::ADDR_ID, 13'h1FFF);
    rd(hbsc_pkg::ADDR_ID);
    chk(r, {12'h000, hbsc_pkg::REVISION_DEFAULT});
    rd(hbsc_pkg::ADDR_CONFIG);
    chk(r, 16'h0001);
    pins(11'h7FF, 0, 0, 0);
    chk(outs, 16'h0020);
    pins(11'h000, 0, 0, 0);
    rd(hbsc_pkg::ADDR_STATUS);
    chk(r, 16'h07FF);
    wr(hbsc_pkg::ADDR_STATUS, 13'h07FF);
    rd(hbsc_pkg::ADDR_STATUS);
    chk(r, 16'h0000);
    wr(hbsc_pkg::ADDR_MASK, 13'h1000);
    pins(11'h100, 0, 0, 0);
    chk(outs, 16'h0000);
    rd(hbsc_pkg::ADDR_STATUS);
    chk(r, 16'h0100);
    rd(hbsc_pkg::ADDR_MASK);
    wr(hbsc_pkg::ADDR_MASK, 13'h1000);
    chk(outs, 16'h0020);
    wr(hbsc_pkg::ADDR_CONFIG, 13'h1008);
    chk(outs, 16'h0040);
    pins(11'h000, 0, 0, 1);
    pins(11'h000, 0, 0, 0);
    chk(16'(pulses), 16'h0000);
    wr(hbsc_pkg::ADDR_CONFIG, 13'h1000);
    pins(11'h000, 1, 0, 1);
    pins(11'h000, 1, 0, 0);
    chk(16'(pulses), 16'h0001);
    wr(hbsc_pkg::ADDR_CONFIG, 13'h0006);
    chk(outs, 16'h0100);
    wr(hbsc_pkg::ADDR_CONFIG, 13'h0005);
    chk(outs, 16'h0200);
    pins(11'h000, 0, 1, 0);
    chk(outs, 16'h0200);
    wr(hbsc_pkg::ADDR_CONFIG, 13'h0003);
    chk(outs, 16'h0100);
    for (int i = 0; i < 8; i++) begin
      wr(hbsc_pkg::ADDR_CONFIG, {3'h0, 2'(i), 3'(7 - i), i[0], 4'h0});
      chk(outs, {6'h00, 2'b01, i[0], 2'h0, 2'(i), 3'(7 - i)});
    end
    hbsc_host_i.xfer(16'hFFFF, 8, r);
    rd(hbsc_pkg::ADDR_STATUS);
    chk(r, 16'h0900);
    end_sim();
  end
endmodule : testbench
